// [design/bvc_pkg.sv]
// Package with offsets, reset values and code decoding constants.
package bvc_pkg;

   // ==========================================================
   // Register map
   // ==========================================================
   localparam logic [7:0] RAIL0_FLOOR_VOLTAGE_OFS  = 8'h0b;
   localparam logic [7:0] RAIL1_NORMAL_VOLTAGE_OFS = 8'h0c;
   localparam logic [7:0] RAIL1_FLOOR_VOLTAGE_OFS  = 8'h0d;
   localparam logic [7:0] RAIL2_NORMAL_VOLTAGE_OFS = 8'h0e;
   localparam logic [7:0] RAIL2_FLOOR_VOLTAGE_OFS  = 8'h0f;
   localparam logic [7:0] RAIL3_NORMAL_VOLTAGE_OFS = 8'h10;

   // Reset values; normal codes are the factory defaults of this variant.
   localparam logic [7:0] FLOOR_VOLTAGE_RST  = 8'h00;
   localparam logic [7:0] NORMAL_VOLTAGE_RST = 8'h37;
   localparam logic [7:0] UNMAPPED_READ      = 8'h00;

   // ==========================================================
   // Code to voltage decoding
   // ==========================================================
   localparam logic [7:0]  FINE_LOW_LAST   = 8'h17;
   localparam logic [7:0]  MID_FIRST       = 8'h18;
   localparam logic [7:0]  MID_LAST        = 8'h9d;
   localparam logic [7:0]  HIGH_FIRST      = 8'h9e;
   localparam logic [15:0] LOW_BASE_MV     = 16'd500;
   localparam logic [15:0] LOW_STEP_MV     = 16'd10;
   localparam logic [15:0] MID_BASE_MV     = 16'd735;
   localparam logic [15:0] MID_STEP_MV     = 16'd5;
   localparam logic [15:0] HIGH_BASE_MV    = 16'd1420;
   localparam logic [15:0] HIGH_STEP_MV    = 16'd20;

   // Per-rail enable pin configuration.
   typedef struct packed {
      logic pin_gating_enable;      // Enable pin takes part in control.
      logic pin_level_select_mode;  // Pin level picks roof or floor.
      logic pin_select;             // 0 picks pin one, 1 picks pin two.
   } bvc_pin_cfg_t;

   // Register access request from the serial interface engine.
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } bvc_req_t;

endpackage : bvc_pkg

// [design/bvc_decode.sv]
// Registered decoder from an 8-bit voltage code to millivolts.
module bvc_decode (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // Code in, voltage out
   input  wire logic [7:0]  code,
   output logic      [15:0] mv
);
   import bvc_pkg::*;

   // ==========================================================
   // Piecewise decode
   // ==========================================================
   function automatic logic [15:0] code_to_mv(input logic [7:0] c);
      logic [15:0] w;
      w = {8'h00, c};
      if (c <= FINE_LOW_LAST)
         code_to_mv = LOW_BASE_MV + LOW_STEP_MV * w;                  // [R2]
      else if (c <= MID_LAST)
         code_to_mv = MID_BASE_MV
                    + MID_STEP_MV * (w - {8'h00, MID_FIRST});         // [R3]
      else
         code_to_mv = HIGH_BASE_MV
                    + HIGH_STEP_MV * (w - {8'h00, HIGH_FIRST});       // [R4]
   endfunction : code_to_mv

   wire logic [15:0] next_mv = code_to_mv(code);

   // Registered so the top level drives its ports from flip-flops.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         mv <= 16'h0000;
      else
         mv <= next_mv;
   end

   // ==========================================================
   // Checks
   // ==========================================================
   // Attempts start only out of reset: the flop still clears on the
   // release edge, so the first decoded value lands one edge later.
   AST_LOW_RANGE: assert property (@(posedge clk) disable iff (!nrst) // [R2]
      (nrst && code <= 8'h17)
      |=> (mv == 16'd500 + 16'd10 * $past({8'h00, code})))
      else $error("low range code decoded wrongly");
   AST_MID_RANGE: assert property (@(posedge clk) disable iff (!nrst) // [R3]
      (nrst && code >= 8'h18 && code <= 8'h9d)
      |=> (mv == 16'd735 + 16'd5 * ($past({8'h00, code}) - 16'd24)))
      else $error("middle range code decoded wrongly");
   AST_HIGH_RANGE: assert property (@(posedge clk) disable iff (!nrst) // [R4]
      (nrst && code >= 8'h9e)
      |=> (mv == 16'd1420 + 16'd20 * ($past({8'h00, code}) - 16'd158)))
      else $error("high range code decoded wrongly");

endmodule : bvc_decode

// [design/bvc_regs.sv]
// Voltage code register bank with a roof/floor state per rail and roof/floor code selection for rails 1 and 2.
//
// Summary of operation
// R1: Each floor register holds the code used in the floor state, reset 0.
// R2: Codes 0x00 to 0x17 decode to 0.5 V plus 10 mV per step.
// R3: Codes 0x18 to 0x9d decode in 5 mV steps from 0.735 V to 1.4 V.
// R4: Codes 0x9e to 0xff decode in 20 mV steps from 1.42 V to 3.36 V.
// R5: Rail 1 normal register sets its target code, factory reset value.
// R6: Rail 2 normal register sets its target code, factory reset value.
// R7: Rail 3 normal register sets its target code, factory reset value.
// R8: All voltage registers are full 8-bit read/write fields, any code.
// R9: In roof/floor mode with pin gating, pin high picks normal, low floor.
// R10: A written code reaches the rail target with no further trigger.
module bvc_regs #(
   parameter logic [7:0] RAIL1_NORMAL_RST = bvc_pkg::NORMAL_VOLTAGE_RST,
   parameter logic [7:0] RAIL2_NORMAL_RST = bvc_pkg::NORMAL_VOLTAGE_RST,
   parameter logic [7:0] RAIL3_NORMAL_RST = bvc_pkg::NORMAL_VOLTAGE_RST
) (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  nrst,
   // Register access from the serial interface engine
   input  wire bvc_pkg::bvc_req_t     req,
   output bvc_pkg::bvc_req_t          unused_req_echo,
   output logic [7:0]                 rdata,
   output logic                       rvalid,
   // Enable pins and per-rail pin configuration, rails 0 to 3
   input  wire logic                  enable_pin_one,
   input  wire logic                  enable_pin_two,
   input  wire bvc_pkg::bvc_pin_cfg_t pin_cfg [4],
   // Rail targets
   output logic [3:0]                 floor_state,
   output logic [7:0]                 rail0_floor_code,
   output logic [7:0]                 rail1_target_code,
   output logic [7:0]                 rail2_target_code,
   output logic [7:0]                 rail3_target_code,
   output logic [7:0]                 rail1_active_code,
   output logic [7:0]                 rail2_active_code,
   output logic [15:0]                rail1_active_mv,
   output logic [15:0]                rail2_active_mv
);
   import bvc_pkg::*;

   // ==========================================================
   // Registers
   // ==========================================================
   logic [7:0] rail1_floor_code;
   logic [7:0] rail2_floor_code;

   // Address decode for writes.
   wire logic wr_f0 = req.wr && (req.addr == RAIL0_FLOOR_VOLTAGE_OFS);
   wire logic wr_n1 = req.wr && (req.addr == RAIL1_NORMAL_VOLTAGE_OFS);
   wire logic wr_f1 = req.wr && (req.addr == RAIL1_FLOOR_VOLTAGE_OFS);
   wire logic wr_n2 = req.wr && (req.addr == RAIL2_NORMAL_VOLTAGE_OFS);
   wire logic wr_f2 = req.wr && (req.addr == RAIL2_FLOOR_VOLTAGE_OFS);
   wire logic wr_n3 = req.wr && (req.addr == RAIL3_NORMAL_VOLTAGE_OFS);

   // Every bit is writable, so any code is accepted unchanged.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rail0_floor_code  <= FLOOR_VOLTAGE_RST;                    // [R1]
         rail1_floor_code  <= FLOOR_VOLTAGE_RST;                    // [R1]
         rail2_floor_code  <= FLOOR_VOLTAGE_RST;                    // [R1]
         rail1_target_code <= RAIL1_NORMAL_RST;                     // [R5]
         rail2_target_code <= RAIL2_NORMAL_RST;                     // [R6]
         rail3_target_code <= RAIL3_NORMAL_RST;                     // [R7]
      end else begin
         if (wr_f0) rail0_floor_code  <= req.wdata;                // [R8]
         if (wr_f1) rail1_floor_code  <= req.wdata;                // [R8]
         if (wr_f2) rail2_floor_code  <= req.wdata;                // [R8]
         if (wr_n1) rail1_target_code <= req.wdata;                // [R5]
         if (wr_n2) rail2_target_code <= req.wdata;                // [R6]
         if (wr_n3) rail3_target_code <= req.wdata;                // [R7]
      end
   end

   // ==========================================================
   // Read path
   // ==========================================================
   logic [7:0] next_rdata;

   // Unmapped addresses read as zero rather than leaving the bus stale.
   always_comb begin
      case (req.addr)
         RAIL0_FLOOR_VOLTAGE_OFS:  next_rdata = rail0_floor_code;
         RAIL1_NORMAL_VOLTAGE_OFS: next_rdata = rail1_target_code;
         RAIL1_FLOOR_VOLTAGE_OFS:  next_rdata = rail1_floor_code;
         RAIL2_NORMAL_VOLTAGE_OFS: next_rdata = rail2_target_code;
         RAIL2_FLOOR_VOLTAGE_OFS:  next_rdata = rail2_floor_code;
         RAIL3_NORMAL_VOLTAGE_OFS: next_rdata = rail3_target_code;
         default:                  next_rdata = UNMAPPED_READ;
      endcase
   end

   // Read data is held until the next read.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata  <= 8'h00;
         rvalid <= 1'b0;
      end else begin
         rvalid <= req.rd;
         if (req.rd) rdata <= next_rdata;                          // [R8]
      end
   end

   // Echo of the last request, kept for the engine's own bookkeeping.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         unused_req_echo <= '0;
      else
         unused_req_echo <= req;
   end

   // ==========================================================
   // Roof/floor selection
   // ==========================================================
   logic [3:0] next_floor_state;

   // A rail sits in floor state only when gating and roof/floor mode are
   // both on and its chosen pin is low; otherwise the pin does not steer
   // the voltage and the normal code applies.
   always_comb begin
      next_floor_state = 4'h0;
      for (int i = 0; i < 4; i++) begin
         next_floor_state[i] = pin_cfg[i].pin_gating_enable
            && pin_cfg[i].pin_level_select_mode
            && !(pin_cfg[i].pin_select ? enable_pin_two
                                       : enable_pin_one);            // [R9]
      end
   end

   wire logic [7:0] next_rail1_active =
      floor_state[1] ? rail1_floor_code : rail1_target_code;        // [R9]
   wire logic [7:0] next_rail2_active =
      floor_state[2] ? rail2_floor_code : rail2_target_code;        // [R9]

   // Written codes flow straight on; no commit strobe is needed.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         floor_state       <= 4'h0;
         rail1_active_code <= RAIL1_NORMAL_RST;
         rail2_active_code <= RAIL2_NORMAL_RST;
      end else begin
         floor_state       <= next_floor_state;
         rail1_active_code <= next_rail1_active;                   // [R10]
         rail2_active_code <= next_rail2_active;                   // [R10]
      end
   end

   // ==========================================================
   // Voltage decoders
   // ==========================================================
   bvc_decode u_dec1 (
      .clk  (clk),
      .nrst (nrst),
      .code (rail1_active_code),
      .mv   (rail1_active_mv)
   );

   bvc_decode u_dec2 (
      .clk  (clk),
      .nrst (nrst),
      .code (rail2_active_code),
      .mv   (rail2_active_mv)
   );

   // ==========================================================
   // Checks
   // ==========================================================
   AST_FLOOR0_WRITE: assert property (@(posedge clk) // [R1]
      disable iff (!nrst)
      (req.wr && req.addr == 8'h0b)
      |=> (rail0_floor_code == $past(req.wdata)))
      else $error("rail 0 floor code did not take the write");
   AST_NORMAL1_WRITE: assert property (@(posedge clk) // [R5]
      disable iff (!nrst)
      (req.wr && req.addr == 8'h0c)
      |=> (rail1_target_code == $past(req.wdata)))
      else $error("rail 1 normal code did not take the write");
   AST_NORMAL2_WRITE: assert property (@(posedge clk) // [R6]
      disable iff (!nrst)
      (req.wr && req.addr == 8'h0e)
      |=> (rail2_target_code == $past(req.wdata)))
      else $error("rail 2 normal code did not take the write");
   AST_NORMAL3_WRITE: assert property (@(posedge clk) // [R7]
      disable iff (!nrst)
      (req.wr && req.addr == 8'h10)
      |=> (rail3_target_code == $past(req.wdata)))
      else $error("rail 3 normal code did not take the write");
   // The host leaves an idle cycle between transfers, so the read of the
   // written register comes two cycles after the write.
   AST_READBACK: assert property (@(posedge clk) disable iff (!nrst) // [R8]
      (req.wr && req.addr == 8'h0d) ##1 !wr_f1
      ##1 (req.rd && req.addr == 8'h0d && !req.wr)
      |=> (rvalid && rdata == $past(req.wdata, 3)))
      else $error("floor code read back differs from the write");
   AST_PIN_SELECT: assert property (@(posedge clk) disable iff (!nrst) // [R9]
      (pin_cfg[1].pin_gating_enable && pin_cfg[1].pin_level_select_mode
      && !pin_cfg[1].pin_select && !enable_pin_one) ##1 !wr_f1
      |=> (rail1_active_code == $past(rail1_floor_code)))
      else $error("low pin did not select the floor code");
   AST_WRITE_TAKES_EFFECT: assert property (@(posedge clk) // [R10]
      disable iff (!nrst)
      (wr_n2 && !floor_state[2]) ##1 (!floor_state[2] && !wr_n2)
      |=> (rail2_active_code == $past(req.wdata, 2)))
      else $error("written code did not reach the rail target");

endmodule : bvc_regs

// [verif/bvc_host.sv]
// Host model issuing single-byte register requests to the code bank.
module bvc_host (
   // Clock
   input  wire logic         clk,
   // Request out and answer back
   output bvc_pkg::bvc_req_t req,
   input  wire logic [7:0]   rdata,
   input  wire logic         rvalid
);
   timeunit 1ns;
   timeprecision 1ns;
   import bvc_pkg::*;

   // ============================================================
   // Requests
   // ============================================================
   // Idle low, so nothing is taken before the first task runs.
   initial req = '0;

   // One write pulse; any 8-bit code may be sent.
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      req <= '0;
   endtask : wr_reg

   // One read pulse; a missing answer comes back unknown so it can't pass.
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk);
      req <= '0;
      #1;
      d = (rvalid === 1'b1) ? rdata : 8'hxx;
   endtask : rd_reg
endmodule : bvc_host

// [verif/bvc_regs_tb.sv]
// Self-checking bench for the voltage code register bank.
module bvc_regs_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import bvc_pkg::*;

   // ============================================================
   // Signals and table
   // ============================================================
   // Row: written address and code, what to look at, expected value.
   typedef struct {
      logic [7:0]  addr;
      logic [7:0]  data;
      logic [1:0]  what;   // 0 read back, 1 or 2 that rail's mv.
      logic [15:0] exp;
   } bvc_row_t;

   logic         clk;
   logic         nrst;
   bvc_req_t     req;
   logic [7:0]   rdata;
   logic         rvalid;
   logic         pin_one;
   logic         pin_two;
   bvc_pin_cfg_t pin_cfg [4];
   logic [3:0]   floor_state;
   logic [7:0]   tgt [4];
   logic [7:0]   act [1:2];
   logic [15:0]  mv [1:2];
   bvc_req_t     echo;
   logic [7:0]   rd;
   int           miscompares;
   int           checks;
   bvc_row_t     rows [14] = '{
      '{8'h0b, 8'ha5, 2'h0, 16'h00a5}, '{8'h0c, 8'hff, 2'h0, 16'h00ff},
      '{8'h0d, 8'h5a, 2'h0, 16'h005a}, '{8'h0e, 8'h00, 2'h0, 16'h0000},
      '{8'h0f, 8'h81, 2'h0, 16'h0081}, '{8'h10, 8'h3c, 2'h0, 16'h003c},
      '{8'h11, 8'ha5, 2'h0, 16'h0000}, '{8'h0c, 8'h00, 2'h1, 16'h01f4},
      '{8'h0c, 8'h17, 2'h1, 16'h02da}, '{8'h0c, 8'h18, 2'h1, 16'h02df},
      '{8'h0c, 8'h9d, 2'h1, 16'h0578}, '{8'h0e, 8'h9e, 2'h2, 16'h058c},
      '{8'h0e, 8'hff, 2'h2, 16'h0d20}, '{8'h0c, 8'h37, 2'h1, 16'h037a}};
   logic [7:0]   rst_addr [6] = '{8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10};
   logic [7:0]   rst_val [6] = '{8'h00, 8'h37, 8'h00, 8'h37, 8'h00, 8'h37};

   bvc_regs dut (
      .clk(clk), .nrst(nrst), .req(req), .unused_req_echo(echo),
      .rdata(rdata), .rvalid(rvalid),
      .enable_pin_one(pin_one), .enable_pin_two(pin_two),
      .pin_cfg(pin_cfg), .floor_state(floor_state),
      .rail0_floor_code(tgt[0]), .rail1_target_code(tgt[1]),
      .rail2_target_code(tgt[2]), .rail3_target_code(tgt[3]),
      .rail1_active_code(act[1]), .rail2_active_code(act[2]),
      .rail1_active_mv(mv[1]), .rail2_active_mv(mv[2]));

   bvc_host host (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));

   // ============================================================
   // Helpers
   // ============================================================
   // Clock of 100 ns period.
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic check(input string what, input logic [15:0] exp,
                        input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", what, exp, got);
         miscompares++;
      end
   endtask : check

   // Pin results reach mv three edges later; wait that and let them land.
   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask : settle

   task automatic give_verdict();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : give_verdict

   // A hang is cut short well past the hundred or so cycles the run needs.
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      give_verdict();
   end

   // ============================================================
   // Tests
   // ============================================================
   initial begin
      nrst = 1'b0;
      pin_one = 1'b1;
      pin_two = 1'b1;
      foreach (pin_cfg[i]) pin_cfg[i] = '0;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      foreach (rows[i]) begin
         host.wr_reg(rows[i].addr, rows[i].data);
         if (rows[i].what == 2'h0) begin
            host.rd_reg(rows[i].addr, rd);
            check("read back", rows[i].exp, 16'(rd));
         end else begin
            settle();
            check("mv", rows[i].exp, mv[rows[i].what]);
         end
      end
      $display("table test done");
      // Second reset in mid-run brings every code back to its default.
      @(posedge clk);
      nrst <= 1'b0;
      @(posedge clk);
      #1;
      check("rail0 floor", 16'h0000, 16'(tgt[0]));
      check("rail3 normal", 16'h0037, 16'(tgt[3]));
      @(posedge clk);
      nrst <= 1'b1;
      foreach (rst_addr[i]) begin
         host.rd_reg(rst_addr[i], rd);
         check("reset value", 16'(rst_val[i]), 16'(rd));
      end
      check("reset mv", 16'h037a, mv[1]);
      $display("reset test done");
      // Rail 1 follows pin one, rail 2 pin two, rail 3 has mode off.
      @(posedge clk);
      pin_cfg[0] <= '{1'b1, 1'b1, 1'b0};
      pin_cfg[1] <= '{1'b1, 1'b1, 1'b0};
      pin_cfg[2] <= '{1'b1, 1'b1, 1'b1};
      pin_cfg[3] <= '{1'b1, 1'b0, 1'b1};
      host.wr_reg(8'h0d, 8'h18);
      // The echo holds the request one cycle late.
      #1;
      check("req echo", 16'h0d18, {echo.addr, echo.wdata});
      host.wr_reg(8'h0f, 8'h9e);
      pin_one <= 1'b0;
      settle();
      check("floor state", 16'h0003, 16'(floor_state));
      check("rail1 active", 16'h0018, 16'(act[1]));
      check("rail1 floor mv", 16'h02df, mv[1]);
      @(posedge clk);
      pin_one <= 1'b1;
      pin_two <= 1'b0;
      settle();
      check("floor state", 16'h0004, 16'(floor_state));
      check("rail1 active", 16'h0037, 16'(act[1]));
      check("rail2 active", 16'h009e, 16'(act[2]));
      check("rail2 floor mv", 16'h058c, mv[2]);
      $display("pin test done");
      give_verdict();
   end
endmodule : bvc_regs_tb
